// ### verilog/ochs_consts.svh
`ifndef OCHS_CONSTS_SVH
`define OCHS_CONSTS_SVH

// Fault counter trip level and restart length
`define OCHS_FAULT_TRIP 3'h7
`define OCHS_FAULT_ZERO 3'h0
`define OCHS_SS_CYCLES 3'h7
// Undervoltage filter count of agreeing cycles
`define OCHS_UV_FILTER 3'h7
// Ramp must reach this percentage before the master clock pulse
`define OCHS_RAMP_GOOD_PCT 90
// Default internal oscillator period in block clocks
`define OCHS_OSC_PERIOD 16'h0100
// Default soft-start cycle length in switching cycles
`define OCHS_SS_LEN 16'h0040
// Cycles without a falling sync edge before falling back to the oscillator
`define OCHS_SYNC_LOSS 16'h0400

`endif

// ### verilog/ochs_pkg.sv
package ochs_pkg;

    // Operating phase of the supervisor
    typedef enum logic [1:0] {
        OCHS_UV_WAIT,
        OCHS_RUN,
        OCHS_RESTART
    } ochs_phase_type;

    // Analog comparator inputs
    typedef struct packed {
        logic over_current;
        logic ramp_done;
    } ochs_sense_type;

    // Gate and soft-start drives
    typedef struct packed {
        logic high_side_on;
        logic low_side_on;
        logic soft_start_run;
        logic power_good;
    } ochs_drive_type;

endpackage

// ### verilog/ochs_sync_in.sv
`timescale 1ns/100ps
`default_nettype none

// Three-stage synchroniser; output changes once stages two and three agree
module ochs_sync_in (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // First stage read only by the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Hold last agreed value while stages disagree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end
endmodule

`default_nettype wire

// ### verilog/ochs_osc.sv
`timescale 1ns/100ps
`default_nettype none

// Programmable free-running oscillator giving a one-cycle tick
module ochs_osc #(
    parameter int PERIOD_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic [PERIOD_W-1:0] period,
    output logic tick
);
    logic [PERIOD_W-1:0] cnt_q;

    initial begin
        if (PERIOD_W < 2) begin
            $error("ochs_osc: PERIOD_W too small");
        end
    end

    // Restart realigns phase to an external edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (restart || cnt_q >= period - PERIOD_W'(1)) begin
            cnt_q <= '0;
            tick <= ~restart;
        end else begin
            cnt_q <= cnt_q + PERIOD_W'(1);
            tick <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// ### verilog/ochs_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`include "ochs_consts.svh"

module ochs_supervisor #(
    parameter int PERIOD_W = 16,
    parameter logic [15:0] OSC_PERIOD = `OCHS_OSC_PERIOD,
    parameter logic [15:0] SS_LEN = `OCHS_SS_LEN,
    parameter logic [15:0] SYNC_LOSS = `OCHS_SYNC_LOSS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic sync_pin,
    input wire ochs_pkg::ochs_sense_type sense_pin,
    input wire logic pwm_request,
    output ochs_pkg::ochs_drive_type drive,
    output logic cycle_start,
    output logic uv_flag,
    output logic [2:0] fault_count
);
    logic sync_lvl;
    logic sync_lvl_q;
    logic oc_lvl;
    logic ramp_lvl;
    logic osc_tick;
    logic sync_fall;
    logic ext_present_q;
    logic [15:0] loss_cnt_q;
    logic master_tick;
    logic oc_seen_q;
    logic hs_blank_q;
    logic ramp_seen_q;
    logic oc_now;
    logic ramp_now;
    logic [2:0] fault_q;
    logic [2:0] uv_cnt_q;
    logic [15:0] ss_cnt_q;
    logic [2:0] ss_left_q;
    ochs_pkg::ochs_phase_type phase_q;

    initial begin
        if (PERIOD_W != 16) begin
            $error("ochs_supervisor: PERIOD_W must be 16");
        end
        if (SS_LEN == 16'h0000 || OSC_PERIOD < 16'h0002) begin
            $error("ochs_supervisor: bad timing parameter");
        end
    end

    // Saturating 3-bit step, used by the undervoltage, fault and soft-start counters
    function automatic logic [2:0] step3(input logic [2:0] v, input logic up);
        if (up) begin
            step3 = (v == 3'h7) ? v : v + 3'h1;
        end else begin
            step3 = (v == `OCHS_FAULT_ZERO) ? v : v - 3'h1;
        end
    endfunction

    // External pins are asynchronous to clk
    ochs_sync_in u_sync_sync (
        .clk(clk),
        .rst(rst),
        .pin(sync_pin),
        .level(sync_lvl)
    );
    ochs_sync_in u_sync_oc (
        .clk(clk),
        .rst(rst),
        .pin(sense_pin.over_current),
        .level(oc_lvl)
    );
    ochs_sync_in u_sync_ramp (
        .clk(clk),
        .rst(rst),
        .pin(sense_pin.ramp_done),
        .level(ramp_lvl)
    );

    // Oscillator phase is pulled to each falling sync edge
    ochs_osc #(
        .PERIOD_W(PERIOD_W)
    ) u_osc (
        .clk(clk),
        .rst(rst),
        .restart(sync_fall),
        .period(OSC_PERIOD),
        .tick(osc_tick)
    );

    // Falling edge of the filtered sync level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_lvl_q <= 1'b0;
        end else begin
            sync_lvl_q <= sync_lvl;
        end
    end
    assign sync_fall = sync_lvl_q & ~sync_lvl;

    // Sync present while edges keep coming; low sync times out to free run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_present_q <= 1'b0;
            loss_cnt_q <= 16'h0000;
        end else if (sync_fall) begin
            ext_present_q <= 1'b1;
            loss_cnt_q <= 16'h0000;
        end else if (loss_cnt_q >= SYNC_LOSS) begin
            ext_present_q <= 1'b0;
        end else begin
            loss_cnt_q <= loss_cnt_q + 16'h0001;
        end
    end

    // Master clock: sync edge when present, else oscillator
    assign master_tick = ext_present_q ? sync_fall : osc_tick;
    assign cycle_start = master_tick;

    // Per-cycle flags: overcurrent seen, ramp reached its good level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_seen_q <= 1'b0;
            ramp_seen_q <= 1'b0;
        end else if (master_tick) begin
            oc_seen_q <= 1'b0;
            ramp_seen_q <= 1'b0;
        end else begin
            if (oc_lvl && drive.high_side_on) begin
                oc_seen_q <= 1'b1;
            end
            if (ramp_lvl) begin
                ramp_seen_q <= 1'b1;
            end
        end
    end

    // Cycle verdicts include an event landing on the closing tick itself;
    // without this the clear at the tick would swallow it, since the clear wins over the set
    assign oc_now = oc_seen_q | (oc_lvl & drive.high_side_on);
    assign ramp_now = ramp_seen_q | ramp_lvl;

    // Pulse-by-pulse limit: blank high side until next cycle start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_blank_q <= 1'b0;
        end else if (master_tick) begin
            hs_blank_q <= 1'b0;
        end else if (oc_lvl && drive.high_side_on) begin
            hs_blank_q <= 1'b1;
        end
    end

    // Undervoltage filter; a short ramp is one cut by the master clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uv_cnt_q <= `OCHS_FAULT_ZERO;
        end else if (master_tick) begin
            if (phase_q == ochs_pkg::OCHS_UV_WAIT) begin
                uv_cnt_q <= ramp_now ? step3(uv_cnt_q, 1'b1) : step3(uv_cnt_q, 1'b0);
            end else begin
                uv_cnt_q <= ramp_now ? step3(uv_cnt_q, 1'b0) : step3(uv_cnt_q, 1'b1);
            end
            if (uv_cnt_q == `OCHS_UV_FILTER - 3'h1 && phase_q == ochs_pkg::OCHS_UV_WAIT
                && ramp_now) begin
                uv_cnt_q <= `OCHS_FAULT_ZERO;
            end
        end
    end

    // Phase, fault counter and soft-start sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_q <= ochs_pkg::OCHS_UV_WAIT;
            fault_q <= `OCHS_FAULT_ZERO;
            ss_cnt_q <= 16'h0000;
            ss_left_q <= `OCHS_FAULT_ZERO;
        end else if (master_tick) begin
            case (phase_q)
                ochs_pkg::OCHS_UV_WAIT: begin
                    fault_q <= `OCHS_FAULT_ZERO;
                    if (ramp_now && uv_cnt_q == `OCHS_UV_FILTER - 3'h1) begin
                        phase_q <= ochs_pkg::OCHS_RUN;
                        ss_cnt_q <= 16'h0000;
                    end
                end
                ochs_pkg::OCHS_RUN: begin
                    if (!ramp_now && uv_cnt_q == `OCHS_UV_FILTER - 3'h1) begin
                        phase_q <= ochs_pkg::OCHS_UV_WAIT;
                    end else if (oc_now) begin
                        fault_q <= step3(fault_q, 1'b1);
                        if (fault_q == `OCHS_FAULT_TRIP - 3'h1) begin
                            phase_q <= ochs_pkg::OCHS_RESTART;
                            ss_left_q <= `OCHS_SS_CYCLES;
                            ss_cnt_q <= 16'h0000;
                        end
                    end else begin
                        fault_q <= step3(fault_q, 1'b0);
                    end
                    if (ss_cnt_q < SS_LEN) begin
                        ss_cnt_q <= ss_cnt_q + 16'h0001;
                    end
                end
                ochs_pkg::OCHS_RESTART: begin
                    // One soft-start cycle spans SS_LEN switching cycles
                    if (ss_cnt_q >= SS_LEN - 16'h0001) begin
                        ss_cnt_q <= 16'h0000;
                        fault_q <= step3(fault_q, 1'b0);
                        ss_left_q <= step3(ss_left_q, 1'b0);
                        if (fault_q == 3'h1) begin
                            phase_q <= ochs_pkg::OCHS_RUN;
                        end
                    end else begin
                        ss_cnt_q <= ss_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    phase_q <= ochs_pkg::OCHS_UV_WAIT;
                end
            endcase
        end
    end

    // Drives: switches off outside run, power good and soft start also on in restart; high side blanked after overcurrent
    always_comb begin
        drive = '0;
        if (phase_q == ochs_pkg::OCHS_RUN) begin
            drive.high_side_on = pwm_request & ~hs_blank_q;
            drive.low_side_on = ~pwm_request;
            drive.power_good = 1'b1;
            drive.soft_start_run = 1'b1;
        end else if (phase_q == ochs_pkg::OCHS_RESTART) begin
            drive.power_good = 1'b1; // both switches stay off
            drive.soft_start_run = 1'b1;
        end
    end

    assign uv_flag = (phase_q == ochs_pkg::OCHS_UV_WAIT);
    assign fault_count = fault_q;
endmodule

`default_nettype wire

// ### test/ochs_partner.sv
`timescale 1ns/100ps
`default_nettype none
module ochs_partner #(
    parameter int SYNC_P = 8
) (
    input wire logic clk,
    input wire logic sync_en,
    input wire logic ramp_ok,
    input wire logic oc_en,
    input wire logic cycle_start,
    input wire ochs_pkg::ochs_drive_type drive,
    output logic sync_pin,
    output ochs_pkg::ochs_sense_type sense_pin
);
    int ph_q = 0;
    int rmp_q = 0;
    // Sync phase and ramp age, both in block clocks
    always @(posedge clk) begin
        ph_q <= (sync_en && ph_q < SYNC_P - 1) ? ph_q + 1 : 0;
        rmp_q <= cycle_start ? 0 : rmp_q + 1;
    end
    // Square wave while enabled, held low otherwise
    assign sync_pin = sync_en && ph_q < SYNC_P / 2;
    // Healthy line: ramp finishes early; weak line: never finishes
    assign sense_pin.ramp_done = ramp_ok && rmp_q >= 2;
    // Switch current only exists while the high side conducts
    assign sense_pin.over_current = oc_en && drive.high_side_on;
endmodule
`default_nettype wire

// ### test/ochs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ochs_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic pwm_request,
    input wire ochs_pkg::ochs_drive_type drive,
    input wire logic cycle_start,
    input wire logic uv_flag,
    input wire logic [2:0] fault_count
);
    logic rs_q;
    logic bl_q;
    logic [3:0] up_q;
    logic [3:0] dn_q;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Restart marker: set at trip, dropped once the count is back at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rs_q <= 1'b0;
            bl_q <= 1'b0;
        end else begin
            rs_q <= (fault_count == 3'h7) || (rs_q && fault_count != 3'h0);
            bl_q <= !cycle_start && (bl_q || ($fell(drive.high_side_on) && pwm_request));
        end
    end
    // Ticks seen in the current uv phase; saturate so a long phase is harmless
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            up_q <= 4'h0;
            dn_q <= 4'h0;
        end else begin
            up_q <= !uv_flag ? 4'h0 : up_q + {3'h0, cycle_start && up_q != 4'hf};
            dn_q <= uv_flag ? 4'h0 : dn_q + {3'h0, cycle_start && dn_q != 4'hf};
        end
    end
    a_blank_hold: assert property (bl_q && !cycle_start |-> !drive.high_side_on)
        else $error("high side back on inside the cycle");
    a_count_tick: assert property ($changed(fault_count) |-> $past(cycle_start))
        else $error("fault count moved off a tick");
    a_count_step: assert property (
        $changed(fault_count) |-> fault_count - $past(fault_count) inside {3'h1, 3'h7})
        else $error("fault count jumped");
    a_trip_off: assert property (
        fault_count == 3'h7 |-> ##[0:1] !drive.high_side_on && !drive.low_side_on)
        else $error("no restart at trip");
    a_restart_off: assert property (
        rs_q && fault_count != 3'h0 |-> !drive.high_side_on && !drive.low_side_on)
        else $error("drive on during restart");
    a_no_wrap: assert property (fault_count == 3'h0 |=> fault_count != 3'h7)
        else $error("fault count wrapped below zero");
    a_uv_off: assert property (uv_flag |-> !drive.high_side_on && !drive.low_side_on)
        else $error("drive on in undervoltage");
    a_pg_filter: assert property ($fell(uv_flag) |-> up_q >= 4'h7)
        else $error("power good too early");
    a_uv_filter: assert property ($rose(uv_flag) |-> dn_q >= 4'h7)
        else $error("undervoltage declared too early");
    c_trip: cover property (fault_count == 3'h7);
    c_pg: cover property ($rose(drive.power_good));
    c_uv: cover property ($rose(uv_flag));
endmodule
bind ochs_supervisor ochs_checker u_chk (.clk(clk), .rst(rst), .pwm_request(pwm_request),
    .drive(drive), .cycle_start(cycle_start), .uv_flag(uv_flag), .fault_count(fault_count));
`default_nettype wire

// ### test/overcurrent_hiccup_and_sync_clock_tb.sv
`timescale 1ns/100ps
`default_nettype none
module overcurrent_hiccup_and_sync_clock_tb;
    localparam logic [15:0] OSC_P = 16'h000a;
    localparam logic [15:0] SS_P = 16'h0002;
    localparam int SYNC_P = 8;
    logic clk;
    logic rst;
    logic pwm_request;
    logic sync_en;
    logic ramp_ok;
    logic oc_en;
    logic sync_pin;
    logic cycle_start;
    logic uv_flag;
    logic [2:0] fault_count;
    ochs_pkg::ochs_sense_type sense_pin;
    ochs_pkg::ochs_drive_type drive;
    int n_mismatch = 0;
    int num_checks = 0;
    int cyc_n = 0;
    int p;

    ochs_supervisor #(.PERIOD_W(16), .OSC_PERIOD(OSC_P), .SS_LEN(SS_P),
        .SYNC_LOSS(16'h0040)) dut (.clk(clk), .rst(rst), .sync_pin(sync_pin),
        .sense_pin(sense_pin), .pwm_request(pwm_request), .drive(drive),
        .cycle_start(cycle_start), .uv_flag(uv_flag), .fault_count(fault_count));
    ochs_partner #(.SYNC_P(SYNC_P)) far (.clk(clk), .sync_en(sync_en), .ramp_ok(ramp_ok),
        .oc_en(oc_en), .cycle_start(cycle_start), .drive(drive), .sync_pin(sync_pin),
        .sense_pin(sense_pin));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard; the full run needs well under a thousand ticks
    always @(posedge clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            n_mismatch = n_mismatch + 1;
            stop_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Inputs move and outputs are read 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Step past n switching ticks, bounded per tick
    task automatic tick(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            k = 0;
            cyc(1);
            while (cycle_start !== 1'b1 && k < 100) begin
                cyc(1);
                k++;
            end
        end
    endtask
    task automatic period();
        tick(1);
        p = 0;
        do begin
            cyc(1);
            p++;
        end while (cycle_start !== 1'b1 && p < 100);
    endtask
    task automatic wait_cnt(input logic [2:0] v);
        for (int i = 0; i < 30 && fault_count !== v; i++) tick(1);
    endtask
    task automatic t_power_up();
        ramp_ok = 1'b1;
        tick(5);
        check(16'(uv_flag), 16'h1);
        tick(6);
        check(16'(uv_flag), 16'h0);
        check(16'(drive), 16'h7);
        period();
        check(16'(p), OSC_P);
        $display("power up done");
    endtask
    task automatic t_hiccup();
        pwm_request = 1'b1;
        oc_en = 1'b1;
        tick(1);
        cyc(6);
        check(16'(drive.high_side_on), 16'h0);
        wait_cnt(3'h7);
        check(16'(fault_count), 16'h7);
        tick(7 * SS_P - 2);
        check(16'(drive[3:2]), 16'h0);
        wait_cnt(3'h0);
        wait_cnt(3'h7);
        check(16'(fault_count), 16'h7);
        oc_en = 1'b0;
        wait_cnt(3'h0);
        tick(3);
        check(16'(fault_count), 16'h0);
        check(16'(drive.high_side_on), 16'h1);
        $display("hiccup done");
    endtask
    task automatic t_sync();
        pwm_request = 1'b0;
        sync_en = 1'b1;
        tick(3);
        period();
        check(16'(p), 16'(SYNC_P));
        sync_en = 1'b0;
        cyc(100);
        period();
        check(16'(p), OSC_P);
        $display("sync done");
    endtask
    task automatic t_uv();
        ramp_ok = 1'b0;
        tick(4);
        check(16'(uv_flag), 16'h0);
        tick(8);
        check(16'(uv_flag), 16'h1);
        check(16'(drive[3:2]), 16'h0);
        $display("undervoltage done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        pwm_request = 1'b0;
        sync_en = 1'b0;
        ramp_ok = 1'b0;
        oc_en = 1'b0;
        cyc(3);
        check(16'(drive), 16'h0);
        check(16'(fault_count), 16'h0);
        rst = 1'b0;
        t_power_up();
        t_hiccup();
        t_sync();
        t_uv();
        stop_test();
    end
endmodule
`default_nettype wire
